// >>> include/spd_regs.vh
`ifndef SPD_REGS_VH
`define SPD_REGS_VH
// Byte addresses of the two 24-bit settings; first address holds bits 23:16
`define SPD_C_ADDR_HI    8'hAA
`define SPD_C_ADDR_MID   8'hAB
`define SPD_C_ADDR_LO    8'hAC
`define SPD_D_ADDR_HI    8'hAD
`define SPD_D_ADDR_MID   8'hAE
`define SPD_D_ADDR_LO    8'hAF
`define SPD_CFG_RESET    24'h000000
// Field positions
`define SPD_FORM_MSB     23
`define SPD_FORM_LSB     20
`define SPD_STYLE_BIT    19
`define SPD_POL_BIT      18
`define SPD_SRC_MSB      17
`define SPD_SRC_LSB      16
`define SPD_RATE_MSB     15
`define SPD_RATE_LSB     0
// Field codes
`define SPD_FORM_SPECIAL 4'hF
`define SPD_SRC_A        2'h0
`define SPD_SRC_B        2'h1
`define SPD_C_LF_CODE    2'h2
`define SPD_D_LF_CODE    2'h3
`define SPD_ALL_BYTES    3'h7
`endif

// >>> rtl/spd_post_divider.v
// What this block does
// RULE_01: Form field picks frame, low or regular clock
// RULE_02: Non-special form: 50% clock, output rate over 24 bits (odd ratios stay high one tick longer than low; ratios below two pass the tick)
// RULE_03: Bits 19:16 join ratio in regular form
// RULE_04: C special, source 10: base rate over low 16
// RULE_05: C special, other source: pulse one source period wide
// RULE_06: Low 16 bits count source periods between pulses
// RULE_07: C source: A, B, low clock, D
// RULE_08: Bit 18 zero positive, one negative pulse
// RULE_09: Bit 19 zero boundary mid-pulse, one leading edge
// RULE_10: D special, source 11: base rate over low 16
// RULE_11: D special, other source: low 16 count periods
// RULE_12: D source: A, B, C, low clock
// RULE_13: New setting applies once all three bytes written
`timescale 1ns/1ps
`default_nettype none
`include "spd_regs.vh"

module spd_post_divider #(
  parameter CFG_W = 24
) (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       synth_out_tick,
  input  wire       synth_base_tick,
  input  wire       post_a_clk,
  input  wire       post_b_clk,
  output reg        post_c_out,
  output reg        post_d_out
);

  localparam MODE_REG   = 2'h0;
  localparam MODE_LOW   = 2'h1;
  localparam MODE_FRAME = 2'h2;

  wire [CFG_W-1:0] cfg_c;
  wire [CFG_W-1:0] cfg_d;
  wire [1:0]       chan_out;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
      wire [7:0] addr_hi  = (i == 0) ? `SPD_C_ADDR_HI : `SPD_D_ADDR_HI;
      wire [7:0] addr_mid = (i == 0) ? `SPD_C_ADDR_MID : `SPD_D_ADDR_MID;
      wire [7:0] addr_lo  = (i == 0) ? `SPD_C_ADDR_LO : `SPD_D_ADDR_LO;
      wire [1:0] lf_code  = (i == 0) ? `SPD_C_LF_CODE : `SPD_D_LF_CODE;

      reg  [CFG_W-1:0] cfg;
      reg  [CFG_W-1:0] shadow;
      reg  [2:0]       written;
      reg  [CFG_W-1:0] div_cnt;
      reg  [15:0]      per_cnt;
      reg              src_q;
      reg              pulse;
      reg              out_q;
      reg  [1:0]       mode;
      reg  [CFG_W-1:0] ratio;
      reg              tick;
      reg              src_lvl;
      reg  [2:0]       next_written;
      reg  [CFG_W-1:0] next_shadow;
      reg  [CFG_W-1:0] next_cnt;

      wire [3:0]  form  = cfg[`SPD_FORM_MSB:`SPD_FORM_LSB];
      wire [1:0]  src   = cfg[`SPD_SRC_MSB:`SPD_SRC_LSB];
      wire [15:0] rate  = cfg[`SPD_RATE_MSB:`SPD_RATE_LSB];
      wire        style = cfg[`SPD_STYLE_BIT];
      wire        pol   = cfg[`SPD_POL_BIT];
      wire [15:0] last  = (rate == 16'h0000) ? 16'h0000 : rate - 16'h0001;
      wire [CFG_W-1:0] half = (ratio + {{(CFG_W-1){1'b0}}, 1'b1}) >> 1;
      wire        src_rise = src_lvl & ~src_q;
      wire        src_fall = ~src_lvl & src_q;
      wire        wrap = (per_cnt >= last);

      always @* begin
        if (form != `SPD_FORM_SPECIAL) begin
          mode  = MODE_REG;                                         // RULE_01
          ratio = cfg;                                              // RULE_02 RULE_03
          tick  = synth_out_tick;
        end else if (src == lf_code) begin
          mode  = MODE_LOW;                                         // RULE_04 RULE_10
          ratio = {{(CFG_W-16){1'b0}}, rate};
          tick  = synth_base_tick;
        end else begin
          mode  = MODE_FRAME;                                       // RULE_05 RULE_11
          ratio = {{(CFG_W-16){1'b0}}, rate};
          tick  = 1'b0;
        end
        // Sibling is the other channel; the low-clock code never reaches here in frame mode
        case (src)
          `SPD_SRC_A: src_lvl = post_a_clk;                         // RULE_07 RULE_12
          `SPD_SRC_B: src_lvl = post_b_clk;                         // RULE_07 RULE_12
          default:    src_lvl = chan_out[1-i];                      // RULE_07 RULE_12
        endcase
      end

      always @* begin
        next_shadow  = shadow;
        next_written = written;
        if (reg_wr) begin
          if (reg_addr == addr_hi) begin
            next_shadow[23:16] = reg_wdata;
            next_written[2]    = 1'b1;
          end
          if (reg_addr == addr_mid) begin
            next_shadow[15:8] = reg_wdata;
            next_written[1]   = 1'b1;
          end
          if (reg_addr == addr_lo) begin
            next_shadow[7:0] = reg_wdata;
            next_written[0]  = 1'b1;
          end
        end
        next_cnt = (div_cnt + {{(CFG_W-1){1'b0}}, 1'b1} >= ratio) ? {CFG_W{1'b0}} :
                   div_cnt + {{(CFG_W-1){1'b0}}, 1'b1};
      end

      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          cfg     <= `SPD_CFG_RESET;
          shadow  <= `SPD_CFG_RESET;
          written <= 3'h0;
        end else begin
          shadow <= next_shadow;
          // Half-written values stay in the shadow so the output never glitches on a torn ratio
          if (next_written == `SPD_ALL_BYTES) begin
            cfg     <= next_shadow;                                 // RULE_13
            written <= 3'h0;                                        // RULE_13
          end else begin
            written <= next_written;
          end
        end
      end

      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          div_cnt <= {CFG_W{1'b0}};
          per_cnt <= 16'h0000;
          src_q   <= 1'b0;
          pulse   <= 1'b0;
          out_q   <= 1'b0;
        end else begin
          src_q <= src_lvl;
          if (mode == MODE_FRAME) begin
            div_cnt <= {CFG_W{1'b0}};
            if (src_rise) begin
              per_cnt <= wrap ? 16'h0000 : per_cnt + 16'h0001;      // RULE_06
            end
            if (style) begin
              // Leading edge style: pulse opens on the boundary rising edge
              if (src_rise) begin
                pulse <= wrap;                                      // RULE_09
              end
            end else begin
              // Boundary sits on the rising edge inside a falling-to-falling pulse
              if (src_fall) begin
                pulse <= wrap;                                      // RULE_09
              end
            end
            out_q <= pulse ^ pol;                                   // RULE_08
          end else begin
            per_cnt <= 16'h0000;
            pulse   <= 1'b0;
            if (tick) begin
              div_cnt <= next_cnt;
              // Ratios below two cannot make a 50% clock from a tick; the tick itself is passed
              if (ratio < {{(CFG_W-2){1'b0}}, 2'h2}) begin
                out_q <= 1'b1;
              end else begin
                out_q <= (next_cnt < half);                         // RULE_02 RULE_04 RULE_10
              end
            end else if (ratio < {{(CFG_W-2){1'b0}}, 2'h2}) begin
              out_q <= 1'b0;
            end
          end
        end
      end

      assign chan_out[i] = out_q;
    end
  endgenerate

  assign cfg_c = g_chan[0].cfg;
  assign cfg_d = g_chan[1].cfg;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 8'h00;
      post_c_out <= 1'b0;
      post_d_out <= 1'b0;
    end else begin
      post_c_out <= chan_out[0];
      post_d_out <= chan_out[1];
      if (reg_rd) begin
        case (reg_addr)
          `SPD_C_ADDR_HI:  reg_rdata <= cfg_c[23:16];
          `SPD_C_ADDR_MID: reg_rdata <= cfg_c[15:8];
          `SPD_C_ADDR_LO:  reg_rdata <= cfg_c[7:0];
          `SPD_D_ADDR_HI:  reg_rdata <= cfg_d[23:16];
          `SPD_D_ADDR_MID: reg_rdata <= cfg_d[15:8];
          `SPD_D_ADDR_LO:  reg_rdata <= cfg_d[7:0];
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/spd_unused_guard.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tb/spd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spd_chk (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       synth_out_tick,
  input wire logic       post_c_out,
  input wire logic       post_d_out
);
  logic wrote;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Pass-through checks only hold while both settings are still at reset value
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) wrote <= 1'b0;
    else if (reg_wr) wrote <= 1'b1;
  end
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_c_pass; !wrote && synth_out_tick |-> ##2 post_c_out; endproperty
  a_c_pass: assert property (p_c_pass) else $error("C missed a tick");
  property p_d_pass; !wrote && synth_out_tick |-> ##2 post_d_out; endproperty
  a_d_pass: assert property (p_d_pass) else $error("D missed a tick");
  property p_c_idle; !wrote && !synth_out_tick |-> ##2 !post_c_out; endproperty
  a_c_idle: assert property (p_c_idle) else $error("C high without tick");
  property p_d_idle; !wrote && !synth_out_tick |-> ##2 !post_d_out; endproperty
  a_d_idle: assert property (p_d_idle) else $error("D high without tick");
  property p_part;
    !wrote && reg_wr && reg_addr == 8'hAA ##1 reg_rd && reg_addr == 8'hAA |=> reg_rdata == 8'h00;
  endproperty
  a_part: assert property (p_part) else $error("partial write became active");
  property p_rd_c;
    reg_wr && reg_addr == 8'hAA ##1 reg_wr && reg_addr == 8'hAB ##1 reg_wr && reg_addr == 8'hAC
    ##1 reg_rd && reg_addr == 8'hAC |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rd_c: assert property (p_rd_c) else $error("C setting not applied");
  c_rd: cover property (reg_rd && reg_addr == 8'hAC);
  c_c_up: cover property ($rose(post_c_out));
  c_d_up: cover property ($rose(post_d_out));
endmodule
bind spd_post_divider spd_chk chk_u (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .synth_out_tick, .post_c_out, .post_d_out);
`default_nettype wire

// >>> tb/spd_partner.sv
`timescale 1ns/1ps
`default_nettype none
module spd_partner (
  input  wire logic clk_sys,
  input  wire logic rstn,
  output wire logic out_tick,
  output wire logic base_tick,
  output wire logic a_clk,
  output wire logic b_clk
);
  int cnt;
  // One 120-cycle pattern, so every rate repeats evenly in a 120-cycle window
  always @(negedge clk_sys or negedge rstn) begin
    if (!rstn) cnt <= 0;
    else cnt <= (cnt == 119) ? 0 : cnt + 1;
  end
  assign out_tick  = rstn && (cnt % 3 == 0);
  assign base_tick = rstn && (cnt % 5 == 0);
  assign a_clk     = (cnt % 8) < 4;
  assign b_clk     = (cnt % 6) < 3;
endmodule
`default_nettype wire

// >>> tb/spd_post_divider_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module spd_post_divider_tb;
  logic       clk_sys = 1'b0;
  logic       rstn    = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr  = 1'b0;
  logic       reg_rd  = 1'b0;
  wire  [7:0] reg_rdata;
  wire        tk_o, tk_b, a_clk, b_clk, pc, pd;
  int         err_count = 0;
  int         samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  spd_partner far_u (.clk_sys, .rstn, .out_tick(tk_o), .base_tick(tk_b), .a_clk, .b_clk);
  spd_post_divider dut_u (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .synth_out_tick(tk_o), .synth_base_tick(tk_b), .post_a_clk(a_clk), .post_b_clk(b_clk),
    .post_c_out(pc), .post_d_out(pd));
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    `CHK(reg_rdata, e)
  endtask
  task run(input logic [7:0] a, input logic [23:0] v, input int r, input int h);
    int nr, nh;
    logic o, p;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v[23:16];
    @(negedge clk_sys);
    reg_addr = a + 8'h01;
    reg_wdata = v[15:8];
    @(negedge clk_sys);
    reg_addr = a + 8'h02;
    reg_wdata = v[7:0];
    @(negedge clk_sys);
    reg_wr = 1'b0;
    rd(a + 8'h02, v[7:0]);
    // Long settle lets a frame counter left from the old setting reach steady state
    repeat (60) @(negedge clk_sys);
    nr = 0;
    nh = 0;
    p = (a == 8'hAA) ? pc : pd;
    repeat (120) begin
      @(negedge clk_sys);
      o = (a == 8'hAA) ? pc : pd;
      nr += (o === 1'b1 && p === 1'b0);
      nh += (o === 1'b1);
      p = o;
    end
    `CHK(nr, r)
    `CHK(nh, h)
  endtask
  task t_reset;
    repeat (20) @(negedge clk_sys);
    for (int i = 0; i < 6; i++) rd(8'(8'hAA + i), 8'h00);
    reg_wr = 1'b1;
    reg_addr = 8'hAA;
    reg_wdata = 8'h55;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    rd(8'hAA, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task t_clock;
    run(8'hAA, 24'h000004, 10, 60);
    run(8'hAA, 24'h000005, 8, 72);
    // Bits 19:18 set without the special form only lengthen the ratio, so the output stays high
    run(8'hAA, 24'h0C0004, 0, 120);
    run(8'hAA, 24'hF20002, 12, 60);
    run(8'hAD, 24'hF30004, 6, 60);
    run(8'hAD, 24'hF30001, 24, 24);
    $display("test clock done");
  endtask
  task t_frame_c;
    run(8'hAA, 24'hF80003, 5, 40);
    run(8'hAA, 24'hFC0003, 5, 80);
    run(8'hAA, 24'hF00003, 5, 40);
    run(8'hAA, 24'hF90002, 10, 60);
    run(8'hAA, 24'hFB0002, 12, 60);
    $display("test frame c done");
  endtask
  task t_frame_d;
    run(8'hAD, 24'hF80003, 5, 40);
    run(8'hAD, 24'hF90002, 10, 60);
    run(8'hAA, 24'hF20002, 12, 60);
    run(8'hAD, 24'hFA0002, 6, 60);
    $display("test frame d done");
  endtask
  task wrap_up;
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset;
    t_clock;
    t_frame_c;
    t_frame_d;
    wrap_up;
  end
endmodule
`default_nettype wire
